/* File: rtl/esf_event_status_flags.sv */
// Event status register flags: over-voltage, thermal warning, thermal shutdown,
// switch change and power-on, each cleared by a status read.
// Assumes event levels come from asynchronous detectors; the read strobe and the
// poll-done pulse come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - The over-voltage flag (bit 6) sets when over-voltage starts and again when it ends.
// - The thermal warning flag (bit 5) sets when the warning starts and again when it ends.
// - The thermal shutdown flag (bit 4) sets when shutdown starts and again when it clears.
// - The switch-change flag (bit 3) sets when any of the 24 sense inputs changes state.
// - The switch-change flag also sets when the first polling cycle after a trigger completes.
// - These four flags reset to zero and return to zero after a status register read.
// - The power-on flag (bit 0) is one after any reset and is cleared by a status read.
module esf_event_status_flags #(
	parameter int unsigned SENSE_COUNT = esf_pkg::SENSE_COUNT
) (
	input  wire logic                             ref_clk_in,
	input  wire logic                             sys_rst_in,
	input  wire logic                             supply_ov_in,
	input  wire logic                             therm_warn_in,
	input  wire logic                             therm_shdn_in,
	input  wire logic [SENSE_COUNT-1:0]           sense_in,
	input  wire logic                             poll_trigger_in,
	input  wire logic                             poll_cycle_done_in,
	input  wire logic                             status_read_in,
	output logic      [esf_pkg::STATUS_WIDTH-1:0] event_status_out
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	localparam int unsigned LVL_W = SENSE_COUNT + 3;

	logic [LVL_W-1:0] meta_reg;
	logic [LVL_W-1:0] sync_reg;
	logic [LVL_W-1:0] prev_reg;
	logic             prev_valid_reg;
	logic [LVL_W-1:0] edge_next;

	// Two stages, then a history copy for edge detection
	// No reset: stages keep sampling through reset
	// So a level already high at release is no false edge
	always_ff @(posedge ref_clk_in) begin
		meta_reg <= {sense_in, therm_shdn_in, therm_warn_in, supply_ov_in};
		sync_reg <= meta_reg;
	end

	// History only valid after first real sample, avoids false edge at reset
	always_ff @(posedge ref_clk_in) begin
		prev_reg <= sync_reg;
		if (sys_rst_in) begin
			prev_valid_reg <= 1'b0;
		end else begin
			prev_valid_reg <= 1'b1;
		end
	end

	assign edge_next = prev_valid_reg ? (sync_reg ^ prev_reg) : '0;

	// ************************************************************
	// First poll completion tracking
	// ************************************************************
	logic poll_armed_reg;
	logic poll_first_done;

	assign poll_first_done = poll_armed_reg & poll_cycle_done_in;

	// Armed by trigger, disarmed by the first completed cycle
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			poll_armed_reg <= 1'b0;
		end else if (poll_trigger_in) begin
			poll_armed_reg <= 1'b1;
		end else if (poll_cycle_done_in) begin
			poll_armed_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Sticky flags, read to clear, set wins
	// ************************************************************
	logic ov_reg;
	logic tw_reg;
	logic tsd_reg;
	logic ssc_reg;
	logic por_reg;
	logic ssc_set;

	assign ssc_set = (|edge_next[LVL_W-1:3]) | poll_first_done;

	// Over-voltage flag on either edge
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			ov_reg <= esf_pkg::FLAG_RESET;
		end else if (edge_next[0]) begin
			ov_reg <= 1'b1;
		end else if (status_read_in) begin
			ov_reg <= 1'b0;
		end
	end

	// Thermal warning flag on either edge
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			tw_reg <= esf_pkg::FLAG_RESET;
		end else if (edge_next[1]) begin
			tw_reg <= 1'b1;
		end else if (status_read_in) begin
			tw_reg <= 1'b0;
		end
	end

	// Thermal shutdown flag on either edge
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			tsd_reg <= esf_pkg::FLAG_RESET;
		end else if (edge_next[2]) begin
			tsd_reg <= 1'b1;
		end else if (status_read_in) begin
			tsd_reg <= 1'b0;
		end
	end

	// Switch change flag
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			ssc_reg <= esf_pkg::FLAG_RESET;
		end else if (ssc_set) begin
			ssc_reg <= 1'b1;
		end else if (status_read_in) begin
			ssc_reg <= 1'b0;
		end
	end

	// Power-on flag, one out of reset
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			por_reg <= esf_pkg::POWER_ON_RESET;
		end else if (status_read_in) begin
			por_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Register image, reserved bits zero
	// ************************************************************
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			event_status_out <= '0;
		end else begin
			event_status_out                          <= '0;
			event_status_out[esf_pkg::BIT_SUPPLY_OV]  <= ov_reg;
			event_status_out[esf_pkg::BIT_THERM_WARN] <= tw_reg;
			event_status_out[esf_pkg::BIT_THERM_SHDN] <= tsd_reg;
			event_status_out[esf_pkg::BIT_SWITCH_CHG] <= ssc_reg;
			event_status_out[esf_pkg::BIT_POWER_ON]   <= por_reg;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	property p_ov_edge;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		edge_next[0] |=> ov_reg ##1 event_status_out[esf_pkg::BIT_SUPPLY_OV];
	endproperty
	a_ov_edge: assert property (p_ov_edge) else $error("ov flag missed edge");

	property p_tw_edge;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		edge_next[1] |=> tw_reg;
	endproperty
	a_tw_edge: assert property (p_tw_edge) else $error("tw flag missed edge");

	property p_tsd_edge;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		$rose(sync_reg[2]) && prev_valid_reg |=> tsd_reg;
	endproperty
	a_tsd_edge: assert property (p_tsd_edge) else $error("tsd flag missed edge");

	property p_ssc_sense;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(prev_valid_reg && sync_reg[LVL_W-1:3] != prev_reg[LVL_W-1:3]) |=> ssc_reg;
	endproperty
	a_ssc_sense: assert property (p_ssc_sense) else $error("ssc missed sense change");

	property p_ssc_poll;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		poll_armed_reg && poll_cycle_done_in
		|=> ssc_reg && (!poll_armed_reg || $past(poll_trigger_in));
	endproperty
	a_ssc_poll: assert property (p_ssc_poll) else $error("ssc missed first poll");

	property p_read_clear;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		status_read_in && !(|edge_next) && !poll_first_done
		|=> !ov_reg && !tw_reg && !tsd_reg && !ssc_reg && !por_reg;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear");

	property p_por_after_reset;
		@(posedge ref_clk_in)
		sys_rst_in ##1 !sys_rst_in |-> por_reg ##1 event_status_out[esf_pkg::BIT_POWER_ON];
	endproperty
	a_por_after_reset: assert property (p_por_after_reset) else $error("por not set");

	property p_set_wins;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		status_read_in && ssc_set |=> ssc_reg;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost on read");

	property p_ov_set_wins;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		status_read_in && edge_next[0] |=> ov_reg;
	endproperty
	a_ov_set_wins: assert property (p_ov_set_wins) else $error("ov lost on read");

endmodule

`default_nettype wire

/* File: rtl/esf_pkg.sv */
// Package for the event status flag block: field positions, widths, reset values.
// Assumes a single 50 MHz logic clock and a synchronous active-high reset.
package esf_pkg;
	localparam int unsigned STATUS_WIDTH   = 24;
	localparam int unsigned SENSE_COUNT    = 24;
	localparam int unsigned BIT_POWER_ON   = 0;
	localparam int unsigned BIT_SWITCH_CHG = 3;
	localparam int unsigned BIT_THERM_SHDN = 4;
	localparam int unsigned BIT_THERM_WARN = 5;
	localparam int unsigned BIT_SUPPLY_OV  = 6;
	localparam logic        FLAG_RESET     = 1'h0;
	localparam logic        POWER_ON_RESET = 1'h1;
endpackage

/* File: tb/esf_host_model.sv */
// Host model: pulses the status read strobe and captures the register image.
// Assumes the device clock is shared and inputs move at its falling edge.
`timescale 1ns/1ps
`default_nettype none

module esf_host_model (
	input  wire logic                             clk_in,
	input  wire logic [esf_pkg::STATUS_WIDTH-1:0] status_in,
	output logic                                  read_out
);
	// One-cycle read strobe, image taken at the sampling edge
	task automatic do_read(output logic [esf_pkg::STATUS_WIDTH-1:0] v);
		@(negedge clk_in);
		read_out = 1'b1;
		@(posedge clk_in);
		v = status_in;
		@(negedge clk_in);
		read_out = 1'b0;
	endtask

	// Idle strobe
	initial read_out = 1'b0;
endmodule

`default_nettype wire

/* File: tb/test_event_status_flags.sv */
// Testbench for the event status flags: events, reads, clears.
// Assumes the host model in tb/ and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_event_status_flags;
	logic        ref_clk_in;
	logic        sys_rst_in;
	logic [2:0]  lvl;
	logic        poll_trigger_in;
	logic        poll_cycle_done_in;
	wire         status_read_in;
	logic [23:0] sense_in;
	wire  [23:0] event_status_out;
	logic [23:0] v;
	int          num_errors = 0;
	int          checks_done = 0;

	`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
		$display("MISMATCH %s exp %h got %h", n, e, g); end end

	esf_event_status_flags uut (
		.ref_clk_in         (ref_clk_in),
		.sys_rst_in         (sys_rst_in),
		.supply_ov_in       (lvl[2]),
		.therm_warn_in      (lvl[1]),
		.therm_shdn_in      (lvl[0]),
		.sense_in           (sense_in),
		.poll_trigger_in    (poll_trigger_in),
		.poll_cycle_done_in (poll_cycle_done_in),
		.status_read_in     (status_read_in),
		.event_status_out   (event_status_out)
	);

	esf_host_model host (
		.clk_in    (ref_clk_in),
		.status_in (event_status_out),
		.read_out  (status_read_in)
	);

	// ************************************************
	// Tasks
	// ************************************************
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask

	task automatic rd_chk(input string n, input logic [23:0] e);
		wt(3);
		host.do_read(v);
		`CHK(n, e, v)
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// 50 MHz clock
	initial begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	// Hang guard
	initial begin
		repeat (3000) @(posedge ref_clk_in);
		num_errors++;
		wrap_up();
	end

	// Main sequence
	initial begin
		{sys_rst_in, lvl, poll_trigger_in, poll_cycle_done_in, sense_in} = '0;
		sys_rst_in = 1'b1;
		wt(10);
		sys_rst_in = 1'b0;
		rd_chk("por", 24'h000001);
		rd_chk("clr", 24'h000000);
		for (int k = 0; k < 3; k++) begin
			for (int p = 0; p < 2; p++) begin
				lvl[k] = ~lvl[k];
				wt(3);
				rd_chk("evt", 24'h000010 << k);
				rd_chk("clr", 24'h000000);
			end
		end
		for (int j = 0; j < 2; j++) begin
			sense_in[j*23] = ~sense_in[j*23];
			wt(3);
			rd_chk("sw", 24'h000008);
		end
		poll_trigger_in = 1'b1;
		wt(1);
		poll_trigger_in = 1'b0;
		poll_cycle_done_in = 1'b1;
		wt(1);
		poll_cycle_done_in = 1'b0;
		rd_chk("poll", 24'h000008);
		poll_cycle_done_in = 1'b1;
		wt(1);
		poll_cycle_done_in = 1'b0;
		rd_chk("poll2", 24'h000000);
		lvl[2] = 1'b1;
		wt(1); // Read strobe lands on the edge that sets the flag
		host.do_read(v);
		`CHK("pre", 24'h000000, v)
		rd_chk("keep", 24'h000040);
		sys_rst_in = 1'b1;
		wt(10);
		sys_rst_in = 1'b0;
		rd_chk("por2", 24'h000001);
		wrap_up();
	end
endmodule

`default_nettype wire
